// ===== rtl/mag_minmax_offset_tracker.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] Accel sample: 14-bit, high byte bits 13..8
// [R2] Peak pairs at 0x45..0x4A, high first
// [R3] Peaks are signed 16-bit, 0.1 uT/LSB
// [R4] Offset equals (max plus min) halved
// [R5] Auto calibration writes offsets each period; here none while maxmin_disable is set
// [R6] Reset or restore loads peaks with 0x8000
// [R7] Host peak writes overwritten next period; here only by a larger signed sample, and not while maxmin_disable is set
// [R8] Accel samples decimated, aligned to mag
// [R9] Accel samples right-justified in pair
// [R10] Reset or restore loads floors with 0x7FFF
// [R11] Peak replaced only by larger signed sample
module mag_minmax_offset_tracker
    import minmax_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic accel_valid,
    input wire logic [13:0] accel_x,
    input wire logic [13:0] accel_y,
    input wire logic [13:0] accel_z,
    input wire logic mag_done,
    input wire logic [15:0] mag_x,
    input wire logic [15:0] mag_y,
    input wire logic [15:0] mag_z,
    input wire logic [2:0] accel_rate_sel,
    input wire logic [2:0] mag_oversample_sel,
    input wire logic maxmin_disable,
    input wire logic maxmin_restore,
    input wire logic auto_cal_enable,
    output logic [15:0] field_offset_x,
    output logic [15:0] field_offset_y,
    output logic [15:0] field_offset_z,
    output logic field_offset_load
);
    logic [13:0] accel_in [AXES];
    logic [15:0] mag_in [AXES];
    logic [15:0] peak [AXES];
    logic [15:0] floor_v [AXES];
    logic [13:0] sync_r [AXES];
    logic [13:0] sync_nxt [AXES];
    logic [15:0] offset_r [AXES];
    logic [15:0] offset_nxt [AXES];
    logic [15:0] offset_calc [AXES];
    logic [7:0] decim_r;
    logic [7:0] decim_nxt;
    logic [7:0] decim_target;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic load_r;
    logic load_nxt;
    logic period_end;

    assign accel_in[0] = accel_x;
    assign accel_in[1] = accel_y;
    assign accel_in[2] = accel_z;
    assign mag_in[0] = mag_x;
    assign mag_in[1] = mag_y;
    assign mag_in[2] = mag_z;
    // Updates only while tracking is enabled
    assign period_end = mag_done && !maxmin_disable; // [R4] [R7]

    // Per-axis trackers, offsets and peak write decode
    genvar a;
    generate
        for (a = 0; a < AXES; a++)
        begin : g_axis
            logic wr_hi;
            logic wr_lo;
            logic [16:0] sum;
            assign wr_hi = reg_write && (reg_addr == FIELD_PEAK_X_HIGH + 8'(2 * a)); // [R2]
            assign wr_lo = reg_write && (reg_addr == FIELD_PEAK_X_LOW + 8'(2 * a)); // [R2]
            // Sign-extended sum keeps the carry, then halve arithmetically
            assign sum = {peak[a][15], peak[a]} + {floor_v[a][15], floor_v[a]}; // [R4]
            assign offset_calc[a] = sum[16:1]; // [R4]

            // Peak register, host writable
            axis_extremum #(
                .MODE(TRACK_MAX),
                .RESTORE(PEAK_RESTORE)
            ) u_peak (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .restore(maxmin_restore),
                .update(period_end),
                .sample(mag_in[a]),
                .wr_high(wr_hi),
                .wr_low(wr_lo),
                .wr_data(reg_wdata),
                .value(peak[a])
            );

            // Floor register; no host port, its write inputs are tied off
            axis_extremum #(
                .MODE(TRACK_MIN),
                .RESTORE(FLOOR_RESTORE)
            ) u_floor (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .restore(maxmin_restore),
                .update(period_end),
                .sample(mag_in[a]),
                .wr_high(1'b0),
                .wr_low(1'b0),
                .wr_data(8'h00),
                .value(floor_v[a])
            );
        end
    endgenerate

    // Decimation target from data rate and oversampling; at most 64 pulses
    always_comb
    begin
        decim_target = DECIM_ONE << 3'(accel_rate_sel[1:0] + mag_oversample_sel[1:0]); // [R8]
    end

    // Next state: accel capture at decimated points, offsets at period end
    always_comb
    begin
        decim_nxt = decim_r;
        load_nxt = 1'b0;
        for (int i = 0; i < AXES; i++)
        begin
            sync_nxt[i] = sync_r[i];
            offset_nxt[i] = offset_r[i];
        end
        if (mag_done)
        begin
            // Realign the decimator on each magnetic sample
            decim_nxt = 8'h00; // [R8]
            for (int i = 0; i < AXES; i++)
                sync_nxt[i] = accel_in[i]; // [R8]
        end
        else if (accel_valid)
        begin
            if (decim_r + 8'h01 >= decim_target)
            begin
                decim_nxt = 8'h00;
                for (int i = 0; i < AXES; i++)
                    sync_nxt[i] = accel_in[i]; // [R8]
            end
            else
                decim_nxt = decim_r + 8'h01;
        end
        if (period_end && auto_cal_enable)
        begin
            // Offsets from the extrema as they stand before this update
            load_nxt = 1'b1; // [R5]
            for (int i = 0; i < AXES; i++)
                offset_nxt[i] = offset_calc[i]; // [R5]
        end
    end

    // Register capture and offset state
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            decim_r <= 8'h00;
            load_r <= 1'b0;
            for (int i = 0; i < AXES; i++)
            begin
                sync_r[i] <= ACCEL_RESET;
                offset_r[i] <= OFFSET_RESET;
            end
        end
        else
        begin
            decim_r <= decim_nxt;
            load_r <= load_nxt;
            for (int i = 0; i < AXES; i++)
            begin
                sync_r[i] <= sync_nxt[i];
                offset_r[i] <= offset_nxt[i];
            end
        end
    end

    // Read mux, registered; unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_read)
        begin
            case (reg_addr)
                ACCEL_SYNC_X_HIGH: rdata_nxt = {2'b00, sync_r[0][13:8]}; // [R1] [R9]
                ACCEL_SYNC_X_LOW: rdata_nxt = sync_r[0][7:0]; // [R1] [R9]
                ACCEL_SYNC_Y_HIGH: rdata_nxt = {2'b00, sync_r[1][13:8]}; // [R1]
                ACCEL_SYNC_Y_LOW: rdata_nxt = sync_r[1][7:0];
                ACCEL_SYNC_Z_HIGH: rdata_nxt = {2'b00, sync_r[2][13:8]}; // [R1]
                ACCEL_SYNC_Z_LOW: rdata_nxt = sync_r[2][7:0];
                FIELD_PEAK_X_HIGH: rdata_nxt = peak[0][15:8]; // [R2] [R3]
                FIELD_PEAK_X_LOW: rdata_nxt = peak[0][7:0]; // [R2]
                FIELD_PEAK_Y_HIGH: rdata_nxt = peak[1][15:8]; // [R2]
                FIELD_PEAK_Y_LOW: rdata_nxt = peak[1][7:0];
                FIELD_PEAK_Z_HIGH: rdata_nxt = peak[2][15:8]; // [R2]
                FIELD_PEAK_Z_LOW: rdata_nxt = peak[2][7:0];
                default: rdata_nxt = READ_RESET;
            endcase
        end
    end

    // Read data holds until the next read
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= READ_RESET;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
    assign field_offset_x = offset_r[0];
    assign field_offset_y = offset_r[1];
    assign field_offset_z = offset_r[2];
    assign field_offset_load = load_r;
endmodule
`default_nettype wire

// ===== rtl/minmax_pkg.sv
package minmax_pkg;
    // Register offsets, byte addresses on the device register port
    localparam logic [7:0] ACCEL_SYNC_X_HIGH = 8'h39;
    localparam logic [7:0] ACCEL_SYNC_X_LOW = 8'h3a;
    localparam logic [7:0] ACCEL_SYNC_Y_HIGH = 8'h3b;
    localparam logic [7:0] ACCEL_SYNC_Y_LOW = 8'h3c;
    localparam logic [7:0] ACCEL_SYNC_Z_HIGH = 8'h3d;
    localparam logic [7:0] ACCEL_SYNC_Z_LOW = 8'h3e;
    localparam logic [7:0] FIELD_PEAK_X_HIGH = 8'h45;
    localparam logic [7:0] FIELD_PEAK_X_LOW = 8'h46;
    localparam logic [7:0] FIELD_PEAK_Y_HIGH = 8'h47;
    localparam logic [7:0] FIELD_PEAK_Y_LOW = 8'h48;
    localparam logic [7:0] FIELD_PEAK_Z_HIGH = 8'h49;
    localparam logic [7:0] FIELD_PEAK_Z_LOW = 8'h4a;
    // Field layout of the acceleration high byte
    localparam int ACCEL_W = 14;
    localparam int ACCEL_HIGH_BITS = 6;
    // Reset and restore patterns
    localparam logic [15:0] PEAK_RESTORE = 16'h8000;
    localparam logic [15:0] FLOOR_RESTORE = 16'h7fff;
    localparam logic [13:0] ACCEL_RESET = 14'h0000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [7:0] READ_RESET = 8'h00;
    localparam int AXES = 3;
    // Decimation: accel samples per period = 2^(rate[1:0]) * 2^(oversample[1:0])
    localparam logic [7:0] DECIM_ONE = 8'h01;
    // Extremum update mode
    typedef enum logic { TRACK_MAX, TRACK_MIN } track_mode_t;
endpackage

// ===== rtl/axis_extremum.sv
`timescale 1ns/10ps
`default_nettype none
// One tracked extremum for one axis: restore, host write, period update
module axis_extremum
    import minmax_pkg::*;
#(
    parameter track_mode_t MODE = TRACK_MAX,
    parameter logic [15:0] RESTORE = PEAK_RESTORE
)(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic restore,
    input wire logic update,
    input wire logic [15:0] sample,
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [7:0] wr_data,
    output logic [15:0] value
);
    logic [15:0] value_r;
    logic [15:0] value_nxt;
    logic better;

    // Signed compare picks a new extremum
    always_comb
    begin
        if (MODE == TRACK_MAX)
            better = $signed(sample) > $signed(value_r); // [R11]
        else
            better = $signed(sample) < $signed(value_r);
        value_nxt = value_r;
        if (restore)
            value_nxt = RESTORE; // [R6] [R10]
        else if (update)
        begin
            // Period update drops any host write in the same cycle
            if (better)
                value_nxt = sample; // [R7] [R11]
        end
        else if (wr_high)
            value_nxt = {wr_data, value_r[7:0]}; // [R7]
        else if (wr_low)
            value_nxt = {value_r[15:8], wr_data};
    end

    // Reset lands on the restore pattern, not the printed zero
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            value_r <= RESTORE; // [R6] [R10]
        else
            value_r <= value_nxt;
    end

    assign value = value_r;
endmodule
`default_nettype wire

// ===== tb/minmax_checker_props.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the field tracker
module minmax_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic accel_valid,
    input wire logic [13:0] accel_x,
    input wire logic mag_done,
    input wire logic maxmin_disable,
    input wire logic maxmin_restore,
    input wire logic auto_cal_enable,
    input wire logic [15:0] field_offset_x,
    input wire logic field_offset_load
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Period end that is allowed to touch the extrema
    logic upd;
    assign upd = mag_done && !maxmin_disable;
    AST_LOAD_ON: assert property (upd && auto_cal_enable && !maxmin_restore |=> field_offset_load)
        else $error("offset load missing");
    AST_LOAD_OFF: assert property (!(upd && auto_cal_enable) |=> !field_offset_load)
        else $error("stray offset load");
    AST_OFF_HOLD: assert property (!field_offset_load |-> $stable(field_offset_x))
        else $error("offset moved without load");
    AST_HIGH_PAD: assert property (reg_read && reg_addr inside {8'h39, 8'h3b, 8'h3d} |=> reg_rdata[7:6] == 2'b00)
        else $error("accel high byte pad not zero");
    AST_RD_HOLD: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved without read");
    AST_RESTORE_PEAK: assert property (reg_read && reg_addr == 8'h45 && maxmin_restore && $past(maxmin_restore) |=> reg_rdata == 8'h80)
        else $error("peak not at restore pattern");
    AST_CAL_RESTORE: assert property (upd && auto_cal_enable && !maxmin_restore && $past(maxmin_restore) |=> field_offset_x == 16'hffff)
        else $error("offset after restore wrong");
    AST_ACCEL_LOW: assert property (mag_done && !accel_valid ##1 !mag_done && !accel_valid ##1 reg_read && reg_addr == 8'h3a |=> reg_rdata == $past(accel_x[7:0], 3))
        else $error("accel low byte not aligned");
    AST_PEAK_WR: assert property (reg_write && reg_addr == 8'h45 && !maxmin_restore && !upd ##1 !upd && !maxmin_restore && !reg_write ##1 reg_read && reg_addr == 8'h45 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("peak byte write lost");
    // Main scenarios reached
    cover property (field_offset_load);
    cover property (upd && $past(maxmin_restore));
    cover property (reg_write && reg_addr == 8'h45);
endmodule
bind mag_minmax_offset_tracker minmax_checker chk_i (.ref_clk, .reset_n, .reg_write, .reg_read,
    .reg_addr, .reg_wdata, .reg_rdata, .accel_valid, .accel_x, .mag_done, .maxmin_disable,
    .maxmin_restore, .auto_cal_enable, .field_offset_x, .field_offset_load);
`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the register port
module host_model (
    input wire logic ref_clk,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle port at time zero
    initial
    begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One byte write; released lines flip so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // One byte read; data taken just after the edge that accepts it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_read = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_mag_minmax_offset_tracker.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mag_minmax_offset_tracker;
    import minmax_pkg::*;
    logic ref_clk, reset_n, accel_valid, mag_done, maxmin_disable, maxmin_restore, auto_cal_enable;
    logic reg_write, reg_read, field_offset_load;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [13:0] accel_x, accel_y, accel_z;
    logic [15:0] mag_x, mag_y, mag_z, field_offset_x, field_offset_y, field_offset_z;
    logic [2:0] accel_rate_sel, mag_oversample_sel;
    int n_errors = 0;
    int n_checks = 0;
    mag_minmax_offset_tracker uut (.ref_clk, .reset_n, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata, .accel_valid, .accel_x, .accel_y, .accel_z, .mag_done, .mag_x,
        .mag_y, .mag_z, .accel_rate_sel, .mag_oversample_sel, .maxmin_disable, .maxmin_restore,
        .auto_cal_enable, .field_offset_x, .field_offset_y, .field_offset_z, .field_offset_load);
    host_model host (.ref_clk, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata);
    // Count and report one comparison
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Byte read and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rd);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rd});
    endtask
    // Peak pair read, high byte at the lower address
    task automatic pchk(input logic [7:0] a, input logic [15:0] exp);
        rchk(a, exp[15:8]);
        rchk(8'(a + 8'h01), exp[7:0]);
    endtask
    // One measurement period end; also drops a pending restore
    task automatic period(input logic [15:0] m, input logic [13:0] a);
        @(posedge ref_clk);
        #1;
        mag_done = 1'b1;
        maxmin_restore = 1'b0;
        {mag_x, mag_y, mag_z} = {m, m, m};
        {accel_x, accel_y, accel_z} = {a, a, a};
        @(posedge ref_clk);
        #1;
        mag_done = 1'b0;
    endtask
    // One raw accel pulse on the x axis
    task automatic pulse(input logic [13:0] a);
        @(posedge ref_clk);
        #1;
        accel_valid = 1'b1;
        accel_x = a;
        @(posedge ref_clk);
        #1;
        accel_valid = 1'b0;
    endtask
    // Verdict
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Hang guard, far beyond the hundred or so cycles needed
    initial
    begin
        #100000;
        n_errors++;
        results();
    end
    // Main sequence
    initial
    begin
        {reset_n, accel_valid, mag_done, maxmin_disable, maxmin_restore, auto_cal_enable} = 6'h00;
        {accel_x, accel_y, accel_z, mag_x, mag_y, mag_z} = '0;
        accel_rate_sel = 3'h0;
        mag_oversample_sel = 3'h0;
        repeat (8) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk("offset x", OFFSET_RESET, field_offset_x);
        for (int i = 0; i < 3; i++) pchk(8'(8'h45 + 2 * i), PEAK_RESTORE);
        for (int i = 0; i < 6; i++) rchk(8'(8'h39 + i), READ_RESET);
        // Read each byte back right after its write, so the write check fires
        for (int i = 0; i < 3; i++)
        begin
            host.wr(8'(8'h45 + 2 * i), 8'h00);
            rchk(8'(8'h45 + 2 * i), 8'h00);
            host.wr(8'(8'h46 + 2 * i), 8'h10);
            rchk(8'(8'h46 + 2 * i), 8'h10);
        end
        // Unmapped read after a nonzero byte must not keep the old data
        rchk(8'h40, 8'h00);
        // Frozen tracking ignores a large sample
        maxmin_disable = 1'b1;
        auto_cal_enable = 1'b1;
        period(16'h7000, 14'h0000);
        chk("load", 16'h0000, {15'h0, field_offset_load});
        pchk(8'h45, 16'h0010);
        maxmin_disable = 1'b0;
        // Negative sample must not beat a small positive peak
        period(16'hff00, 14'h2abc);
        rchk(8'h3a, 8'hbc);
        rchk(8'h39, 8'h2a);
        pchk(8'h47, 16'h0010);
        period(16'h0200, 14'h0000);
        pchk(8'h45, 16'h0200);
        // Decimated capture at one accel pulse per sample
        pulse(14'h1234);
        rchk(8'h3a, 8'h34);
        rchk(8'h39, 8'h12);
        // Four pulses per sample: only the fourth is kept
        accel_rate_sel = 3'h1;
        mag_oversample_sel = 3'h1;
        for (int i = 1; i < 4; i++) pulse(14'(14'h0100 + i));
        rchk(8'h3a, 8'h34);
        pulse(14'h0104);
        rchk(8'h3a, 8'h04);
        // Restore, then offsets from restored and tracked extrema
        maxmin_restore = 1'b1;
        pchk(8'h45, PEAK_RESTORE);
        period(16'h0064, 14'h0000);
        chk("load", 16'h0001, {15'h0, field_offset_load});
        chk("offset x", 16'hffff, field_offset_x);
        period(16'h0100, 14'h0000);
        chk("offset y", 16'h0064, field_offset_y);
        chk("offset z", 16'h0064, field_offset_z);
        @(posedge ref_clk);
        #1;
        chk("load", 16'h0000, {15'h0, field_offset_load});
        // Calibration off: extrema still track, offsets stay put
        auto_cal_enable = 1'b0;
        period(16'h0300, 14'h0000);
        chk("load", 16'h0000, {15'h0, field_offset_load});
        chk("offset z", 16'h0064, field_offset_z);
        pchk(8'h45, 16'h0300);
        results();
    end
endmodule
`default_nettype wire
